// *** hw/jid_decode.v ***
// JTAG instruction decoder with data-register selection and service bus access tracking.
`timescale 1ns/1ns
`default_nettype none
`include "jid_consts.vh"

module jid_decode #(
	parameter [31:0] ID_VALUE = 32'h0000_0001 // Arbitrary identification value.
) (
	input  wire        hclk,             // System clock.
	input  wire        hresetn,          // Asynchronous reset, active low.
	input  wire        hsel,             // Slave select.
	input  wire [31:0] haddr,            // Byte address.
	input  wire [1:0]  htrans,           // Transfer type.
	input  wire        hwrite,           // Write when high.
	input  wire [2:0]  hsize,            // Transfer size.
	input  wire        hready,           // Bus ready.
	input  wire [31:0] hwdata,           // Write data.
	output reg         hreadyout,        // Slave ready.
	output reg  [31:0] hrdata,           // Read data.
	output reg         hresp,            // Response, always OKAY.
	input  wire        tck,              // Test clock pin.
	input  wire        tms,              // Test mode select pin.
	input  wire        tdi,              // Test data in pin.
	input  wire        trst_n,           // Test reset pin, active low.
	output reg         tdo,              // Test data out.
	output reg         tdo_oe,           // Drive enable for tdo.
	input  wire [7:0]  bscan_pins,       // Pin values seen by the boundary chain.
	output reg  [7:0]  bscan_drive,      // Boundary latch values driven to pins.
	output reg         bscan_drive_en,   // Pins driven from the boundary latch.
	output reg         static_reset_out, // Persistent device reset.
	output reg         cpu_halt,         // Processor stop request.
	output reg         chip_erase        // One-cycle erase pulse.
);

	localparam [3:0] ST_TLR = 4'h0, ST_RTI = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3;
	localparam [3:0] ST_SH_DR = 4'h4, ST_EX1_DR = 4'h5, ST_PA_DR = 4'h6, ST_EX2_DR = 4'h7;
	localparam [3:0] ST_UPD_DR = 4'h8, ST_SEL_IR = 4'h9, ST_CAP_IR = 4'hA, ST_SH_IR = 4'hB;
	localparam [3:0] ST_EX1_IR = 4'hC, ST_PA_IR = 4'hD, ST_EX2_IR = 4'hE, ST_UPD_IR = 4'hF;

	function [5:0] jid_dr_len;
		input [4:0] op;
		begin
			case (op)
				`JID_OP_IDCODE: jid_dr_len = `JID_LEN_ID;
				`JID_OP_SAMPLE, `JID_OP_EXTEST, `JID_OP_INTEST: jid_dr_len = `JID_LEN_BSC;
				`JID_OP_NEXUS, `JID_OP_WORD, `JID_OP_BLOCK,
				`JID_OP_MEMSVC, `JID_OP_SIZED: jid_dr_len = `JID_LEN_SAB;
				`JID_OP_CANCEL: jid_dr_len = `JID_LEN_CANCEL;
				`JID_OP_SYNC: jid_dr_len = `JID_LEN_SYNC;
				default: jid_dr_len = `JID_LEN_ONE;
			endcase
		end
	endfunction

	function jid_restricted;
		input [4:0] op;
		begin
			jid_restricted = (op == `JID_OP_NEXUS) || (op == `JID_OP_WORD) ||
				(op == `JID_OP_BLOCK) || (op == `JID_OP_SIZED);
		end
	endfunction

	function jid_addr_data;
		input [4:0] op;
		begin
			jid_addr_data = (op == `JID_OP_NEXUS) || (op == `JID_OP_WORD) ||
				(op == `JID_OP_MEMSVC) || (op == `JID_OP_SIZED);
		end
	endfunction

	reg [3:0]             pin_s1;
	reg [3:0]             pin_s2;
	reg                   tck_d;
	reg [7:0]             bsc_s1;
	reg [7:0]             bsc_s2;
	reg [3:0]             state;
	reg [3:0]             next_state;
	reg [4:0]             instr;
	reg [4:0]             ir_sr;
	reg [`JID_DR_W-1:0]   dr_sr;
	reg [`JID_DR_W-1:0]   next_dr_sr;
	reg [`JID_DR_W-1:0]   cap_val;
	reg [5:0]             dr_cnt;
	reg [7:0]             bsc_latch;
	reg                   sec_fuse;
	reg                   flash_rst;
	reg                   prot_en;
	reg                   busy;
	reg                   sync_run;
	reg [`JID_SYNC_W-1:0] sync_cnt;
	reg                   sab_err;
	reg                   data_mode;
	reg                   sab_dir;
	reg [31:0]            sab_addr;
	reg [31:0]            sab_wdata;
	reg [31:0]            sab_rdata;
	reg                   wr_pend;
	reg [11:0]            wr_ofs;

	wire                  s_tck    = pin_s2[3];
	wire                  s_tms    = pin_s2[2];
	wire                  s_tdi    = pin_s2[1];
	wire                  s_trst_n = pin_s2[0];
	wire                  tck_rise = s_tck & ~tck_d;
	wire                  tck_fall = ~s_tck & tck_d;
	wire [5:0]            dr_len   = jid_dr_len(instr);
	wire [`JID_DR_W-1:0]  dr_val   = dr_sr >> (dr_len - dr_cnt);
	wire                  protect  = prot_en & (sec_fuse | flash_rst | static_reset_out);
	wire                  blocked  = jid_restricted(instr) & protect;
	wire                  upd_dr   = tck_rise & (state == ST_UPD_DR);
	wire                  upd_ir   = tck_rise & (state == ST_UPD_IR);
	wire                  can_go   = upd_dr & ~busy & ~blocked;
	wire                  ahb_go   = hsel & htrans[1] & hready;
	wire                  done_wr  = wr_pend & (wr_ofs == `JID_OFS_DONE);

	always @* begin
		case (state)
			ST_TLR:    next_state = s_tms ? ST_TLR : ST_RTI;
			ST_RTI:    next_state = s_tms ? ST_SEL_DR : ST_RTI;
			ST_SEL_DR: next_state = s_tms ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: next_state = s_tms ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR:  next_state = s_tms ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: next_state = s_tms ? ST_UPD_DR : ST_PA_DR;
			ST_PA_DR:  next_state = s_tms ? ST_EX2_DR : ST_PA_DR;
			ST_EX2_DR: next_state = s_tms ? ST_UPD_DR : ST_SH_DR;
			ST_UPD_DR: next_state = s_tms ? ST_SEL_DR : ST_RTI;
			ST_SEL_IR: next_state = s_tms ? ST_TLR : ST_CAP_IR;
			ST_CAP_IR: next_state = s_tms ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR:  next_state = s_tms ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: next_state = s_tms ? ST_UPD_IR : ST_PA_IR;
			ST_PA_IR:  next_state = s_tms ? ST_EX2_IR : ST_PA_IR;
			ST_EX2_IR: next_state = s_tms ? ST_UPD_IR : ST_SH_IR;
			ST_UPD_IR: next_state = s_tms ? ST_SEL_DR : ST_RTI;
			default:   next_state = ST_TLR;
		endcase
	end

	// Shift toward bit 0 with new data entering at the top of the active length.
	always @* begin
		next_dr_sr = dr_sr >> 1;
		next_dr_sr[dr_len - 6'd1] = s_tdi;
	end

	always @* begin
		cap_val = {`JID_DR_W{1'b0}};
		case (instr)
			`JID_OP_IDCODE: cap_val[31:0] = ID_VALUE;
			`JID_OP_SAMPLE, `JID_OP_EXTEST, `JID_OP_INTEST: cap_val[7:0] = bsc_s2;
			`JID_OP_BLOCK: cap_val = {sab_rdata, sab_err, busy};
			`JID_OP_CANCEL, `JID_OP_SYNC: cap_val[1:0] = {sab_err, busy};
			`JID_OP_RESET: cap_val[0] = static_reset_out;
			default: begin
				if (jid_addr_data(instr)) begin
					cap_val[1:0] = {sab_err, busy};
					if (data_mode)
						cap_val[33:2] = sab_rdata;
				end
			end
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_s1 <= 4'h0;
			pin_s2 <= 4'h0;
			tck_d <= 1'b0;
			bsc_s1 <= 8'h00;
			bsc_s2 <= 8'h00;
		end else begin
			pin_s1 <= {tck, tms, tdi, trst_n};
			pin_s2 <= pin_s1;
			tck_d <= pin_s2[3];
			bsc_s1 <= bscan_pins;
			bsc_s2 <= bsc_s1;
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= ST_TLR;
			instr <= `JID_OP_IDCODE;
			ir_sr <= 5'h00;
			dr_sr <= {`JID_DR_W{1'b0}};
			dr_cnt <= 6'd0;
			tdo <= 1'b0;
			tdo_oe <= 1'b0;
			bsc_latch <= 8'h00;
			bscan_drive <= 8'h00;
			bscan_drive_en <= 1'b0;
			static_reset_out <= 1'b0;
			cpu_halt <= 1'b0;
			chip_erase <= 1'b0;
			sec_fuse <= 1'b0;
			flash_rst <= 1'b0;
			prot_en <= 1'b1;
			busy <= 1'b0;
			sync_run <= 1'b0;
			sync_cnt <= {`JID_SYNC_W{1'b0}};
			sab_err <= 1'b1;
			data_mode <= 1'b0;
			sab_dir <= 1'b0;
			sab_addr <= 32'h0000_0000;
			sab_wdata <= 32'h0000_0000;
			sab_rdata <= 32'h0000_0000;
		end else begin
			chip_erase <= 1'b0;
			if (!s_trst_n) begin
				state <= ST_TLR;
				instr <= `JID_OP_IDCODE;
			end else if (tck_rise) begin
				state <= next_state;
				case (state)
					ST_TLR: instr <= `JID_OP_IDCODE;
					ST_CAP_IR: ir_sr <= {protect, `JID_IR_CAPTURE};
					ST_SH_IR: ir_sr <= {s_tdi, ir_sr[4:1]};
					ST_UPD_IR: instr <= ir_sr;
					ST_CAP_DR: begin
						dr_sr <= cap_val;
						dr_cnt <= 6'd0;
					end
					ST_SH_DR: begin
						dr_sr <= next_dr_sr;
						if (dr_cnt != dr_len)
							dr_cnt <= dr_cnt + 6'd1;
					end
					default: ;
				endcase
			end
			if (tck_fall) begin
				tdo <= (state == ST_SH_IR) ? ir_sr[0] : dr_sr[0];
				tdo_oe <= (state == ST_SH_IR) || (state == ST_SH_DR);
			end
			cpu_halt <= (instr == `JID_OP_HALT);
			bscan_drive_en <= (instr == `JID_OP_EXTEST) || (instr == `JID_OP_INTEST) ||
				(instr == `JID_OP_CLAMP);
			bscan_drive <= bsc_latch;
			if (upd_ir && ir_sr != instr)
				data_mode <= 1'b0;
			if (upd_ir && ir_sr == `JID_OP_ERASE) begin
				chip_erase <= 1'b1;
				sec_fuse <= 1'b0;
			end else if (wr_pend && wr_ofs == `JID_OFS_CFG) begin
				sec_fuse <= hwdata[`JID_CFG_FUSE];
			end
			if (wr_pend && wr_ofs == `JID_OFS_CFG) begin
				flash_rst <= hwdata[`JID_CFG_FLRST];
				prot_en <= hwdata[`JID_CFG_PROTEN];
			end
			if (upd_dr && (instr == `JID_OP_SAMPLE || instr == `JID_OP_EXTEST ||
				instr == `JID_OP_INTEST))
				bsc_latch <= dr_val[7:0];
			if (upd_dr && instr == `JID_OP_RESET)
				static_reset_out <= dr_val[0];
			// Clears first, so a start in the same cycle leaves busy set.
			if (upd_ir && ir_sr == `JID_OP_CANCEL) begin
				busy <= 1'b0;
				sync_run <= 1'b0;
				if (busy)
					sab_err <= 1'b1;
			end
			if (sync_run) begin
				sync_cnt <= sync_cnt - {{(`JID_SYNC_W-1){1'b0}}, 1'b1};
				if (sync_cnt == {{(`JID_SYNC_W-1){1'b0}}, 1'b1}) begin
					sync_run <= 1'b0;
					busy <= 1'b0;
				end
			end
			if (done_wr && busy && !sync_run) begin
				busy <= 1'b0;
				sab_err <= hwdata[`JID_DONE_ERR];
			end
			if (wr_pend && wr_ofs == `JID_OFS_RDATA)
				sab_rdata <= hwdata;
			if (can_go && instr == `JID_OP_SYNC && dr_val[15:0] != 16'h0000) begin
				sync_cnt <= dr_val[15:0];
				sync_run <= 1'b1;
				busy <= 1'b1;
			end
			if (can_go && instr == `JID_OP_BLOCK) begin
				sab_addr <= sab_addr + `JID_ADDR_STEP;
				if (!sab_dir)
					sab_wdata <= dr_val[33:2];
				busy <= 1'b1;
				sab_err <= 1'b0;
			end
			if (can_go && jid_addr_data(instr)) begin
				if (!data_mode) begin
					sab_addr <= dr_val[32:1];
					sab_dir <= dr_val[0];
					data_mode <= 1'b1;
					if (dr_val[0]) begin
						busy <= 1'b1;
						sab_err <= 1'b0;
					end
				end else begin
					data_mode <= 1'b0;
					if (!sab_dir) begin
						sab_wdata <= dr_val[33:2];
						busy <= 1'b1;
						sab_err <= 1'b0;
					end
				end
			end
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h0000_0000;
			wr_pend <= 1'b0;
			wr_ofs <= 12'h000;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend <= ahb_go & hwrite;
			wr_ofs <= haddr[11:0];
			if (ahb_go && !hwrite) begin
				case (haddr[11:0])
					`JID_OFS_CFG: hrdata <= {29'h0, prot_en, flash_rst, sec_fuse};
					`JID_OFS_STATUS: hrdata <= {18'h0, sync_run, cpu_halt, static_reset_out,
						protect, sab_err, busy, sab_dir, data_mode, 1'b0, instr};
					`JID_OFS_ADDR: hrdata <= sab_addr;
					`JID_OFS_WDATA: hrdata <= sab_wdata;
					`JID_OFS_RDATA: hrdata <= sab_rdata;
					`JID_OFS_BSC: hrdata <= {24'h0, bsc_latch};
					default: hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

endmodule // jid_decode
`default_nettype wire

// *** hw/jid_consts.vh ***
// Constants for the JTAG instruction decoder: opcodes, lengths, register map.
`ifndef JID_CONSTS_VH
`define JID_CONSTS_VH

`define JID_IR_W          5
`define JID_OP_IDCODE     5'h01
`define JID_OP_SAMPLE     5'h02
`define JID_OP_EXTEST     5'h03
`define JID_OP_INTEST     5'h04
`define JID_OP_CLAMP      5'h06
`define JID_OP_RESET      5'h0C
`define JID_OP_ERASE      5'h0F
`define JID_OP_NEXUS      5'h10
`define JID_OP_WORD       5'h11
`define JID_OP_BLOCK      5'h12
`define JID_OP_CANCEL     5'h13
`define JID_OP_MEMSVC     5'h14
`define JID_OP_SIZED      5'h15
`define JID_OP_SYNC       5'h17
`define JID_OP_HALT       5'h1C
`define JID_OP_BYPASS     5'h1F
`define JID_IR_CAPTURE    4'h1

`define JID_DR_W          34
`define JID_LEN_ID        6'd32
`define JID_LEN_SAB       6'd34
`define JID_LEN_BSC       6'd8
`define JID_LEN_CANCEL    6'd2
`define JID_LEN_SYNC      6'd16
`define JID_LEN_ONE       6'd1
`define JID_BSC_W         8
`define JID_SYNC_W        16
`define JID_ADDR_STEP     32'h0000_0004

`define JID_OFS_CFG       12'h000
`define JID_OFS_STATUS    12'h004
`define JID_OFS_ADDR      12'h008
`define JID_OFS_WDATA     12'h00C
`define JID_OFS_RDATA     12'h010
`define JID_OFS_DONE      12'h014
`define JID_OFS_BSC       12'h018

`define JID_CFG_FUSE      0
`define JID_CFG_FLRST     1
`define JID_CFG_PROTEN    2
`define JID_DONE_ERR      1
`define JID_CFG_RESET     3'h4

`endif

// *** tb/jid_decode_monitor.sv ***
// Assertion checker for the instruction decoder ports.
`timescale 1ns/1ns
`default_nettype none
module jid_decode_monitor (
	input wire logic        hclk,             // Clock.
	input wire logic        hresetn,          // Reset.
	input wire logic        hsel,             // Select.
	input wire logic [1:0]  htrans,           // Transfer.
	input wire logic        hwrite,           // Write.
	input wire logic        hready,           // Ready in.
	input wire logic        hreadyout,        // Ready out.
	input wire logic        hresp,            // Response.
	input wire logic [31:0] hrdata,           // Read data.
	input wire logic        tck,              // Test clock.
	input wire logic        trst_n,           // Test reset.
	input wire logic        tdo,              // Test out.
	input wire logic        tdo_oe,           // Test out enable.
	input wire logic        bscan_drive_en,   // Pins from latch.
	input wire logic        static_reset_out, // Static reset.
	input wire logic        cpu_halt,         // Halt.
	input wire logic        chip_erase        // Erase pulse.
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic [3:0] quiet;
	logic       tck_q;
	logic       trst_q;
	// Cycles since tck or trst_n last moved; with those pins at rest nothing decoded may change.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			quiet  <= 4'h0;
			tck_q  <= 1'b0;
			trst_q <= 1'b1;
		end else begin
			tck_q  <= tck;
			trst_q <= trst_n;
			if (tck != tck_q || trst_n != trst_q)
				quiet <= 4'h0;
			else if (quiet != 4'hF)
				quiet <= quiet + 4'h1;
		end
	end
	property p_bus_okay;
		hreadyout && !hresp;
	endproperty
	a_bus_okay: assert property (p_bus_okay) else $error("bus answer not ready or not okay");
	property p_erase_pulse;
		chip_erase |=> !chip_erase;
	endproperty
	a_erase_pulse: assert property (p_erase_pulse) else $error("erase pulse too long");
	property p_halt_excl;
		!(cpu_halt && bscan_drive_en);
	endproperty
	a_halt_excl: assert property (p_halt_excl) else $error("halt with clamp drive");
	property p_quiet_instr;
		quiet >= 4'h9 |-> $stable(cpu_halt) && $stable(bscan_drive_en);
	endproperty
	a_quiet_instr: assert property (p_quiet_instr) else $error("instruction moved");
	property p_quiet_tdo;
		quiet >= 4'h9 |-> $stable(tdo) && $stable(tdo_oe);
	endproperty
	a_quiet_tdo: assert property (p_quiet_tdo) else $error("tdo moved at rest");
	property p_quiet_rst;
		quiet >= 4'h9 |-> $stable(static_reset_out) && !chip_erase;
	endproperty
	a_quiet_rst: assert property (p_quiet_rst) else $error("reset or erase at rest");
	property p_trst_home;
		!trst_n [*6] |-> !cpu_halt && !bscan_drive_en;
	endproperty
	a_trst_home: assert property (p_trst_home) else $error("test reset kept instr");
	property p_hrdata_hold;
		!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata);
	endproperty
	a_hrdata_hold: assert property (p_hrdata_hold) else $error("read data moved");
	c_erase: cover property (chip_erase);
	c_static: cover property ($rose(static_reset_out));
	c_halt: cover property ($rose(cpu_halt));
endmodule // jid_decode_monitor
bind jid_decode jid_decode_monitor mon_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.hrdata(hrdata), .tck(tck), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe),
	.bscan_drive_en(bscan_drive_en), .static_reset_out(static_reset_out),
	.cpu_halt(cpu_halt), .chip_erase(chip_erase));
`default_nettype wire

// *** tb/jid_host_model.sv ***
// Behavioural test controller driving the link pins.
`timescale 1ns/1ns
`default_nettype none
module jid_host_model (
	input wire logic hclk,   // System clock, used only to place the pin edges.
	output var logic tck,    // Test clock.
	output var logic tms,    // Mode select.
	output var logic tdi,    // Data in.
	output var logic trst_n, // Test reset.
	input wire logic tdo     // Data out.
);
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
		trst_n = 1'b0;
	end
	// One 125 ns link cycle; tdo is taken just before the rising edge.
	task automatic step(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#62;
		q = tdo;
		tck = 1'b1;
		#63;
		tck = 1'b0;
	endtask
	task automatic home();
		logic q;
		// Starting just after a clock edge keeps every pin change off the sampling edge.
		@(posedge hclk);
		#2;
		trst_n = 1'b0;
		#400;
		trst_n = 1'b1;
		#400;
		step(1'b0, 1'b0, q);
	endtask
	// Scan from idle back to idle; tdi is inverted outside the shift.
	task automatic shift(input logic ir, input int n, input logic [33:0] din,
			output logic [33:0] dout);
		logic q;
		@(posedge hclk);
		#2;
		dout = '0;
		step(1'b1, ~tdi, q);
		if (ir)
			step(1'b1, ~tdi, q);
		step(1'b0, ~tdi, q);
		step(1'b0, ~tdi, q);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
		step(1'b1, ~din[n-1], q);
		step(1'b0, din[n-1], q);
	endtask
endmodule // jid_host_model
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the instruction decoder.
`timescale 1ns/1ns
`default_nettype none
`include "jid_consts.vh"
module tb_top;
	localparam logic [31:0] ID_VAL = 32'h1234_5678; // Arbitrary identification value.
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic [31:0] rv;
	logic [33:0] so;
	logic [7:0]  pins;
	wire         hreadyout, hresp, tck, tms, tdi, trst_n, tdo, tdo_oe;
	wire         bscan_drive_en, static_reset_out, cpu_halt, chip_erase;
	wire  [31:0] hrdata;
	wire  [7:0]  bscan_drive;
	int          num_errors = 0;
	int          total_checks = 0;
	int          n_erase = 0;
	jid_decode #(.ID_VALUE(ID_VAL)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
		.hwdata(hwdata), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .tck(tck),
		.tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe),
		.bscan_pins(pins), .bscan_drive(bscan_drive), .bscan_drive_en(bscan_drive_en),
		.static_reset_out(static_reset_out), .cpu_halt(cpu_halt), .chip_erase(chip_erase));
	jid_host_model host (.hclk(hclk), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
		.tdo(tdo));
	task automatic chk(input string what, input logic [33:0] seen, input logic [33:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {20'h0, a};
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rv = hrdata;
	endtask
	task automatic ir(input logic [4:0] op);
		host.shift(1'b1, 5, {29'h0, op}, so);
	endtask
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	initial begin
		#400_000;
		num_errors++;
		wrap_up();
	end
	always @(posedge hclk)
		if (chip_erase === 1'b1)
			n_erase++;
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hwdata = 32'h0;
		pins = 8'h96;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		host.home();
		ahb(1'b0, `JID_OFS_CFG, 32'h0);
		chk("cfg", rv, `JID_CFG_RESET);
		ahb(1'b0, `JID_OFS_STATUS, 32'h0);
		chk("instr", rv[4:0], `JID_OP_IDCODE);
		ahb(1'b0, 12'h100, 32'h0);
		chk("unmapped", rv, 32'h0);
		host.shift(1'b0, 32, 34'h0, so);
		chk("idcode", so[31:0], ID_VAL);
		$display("test reset done");
		for (int op = 0; op < 32; op++) begin
			ir(op[4:0]);
			chk("ir capture", so[4:0], 5'h01);
			ahb(1'b0, `JID_OFS_STATUS, 32'h0);
			chk("instr", rv[4:0], op[4:0]);
			chk("halt", cpu_halt, op == 'h1C);
			chk("clamp", bscan_drive_en, op inside {3, 4, 6});
			if (!(op inside {[1:4], 'hC, 'hF, ['h10:'h15], 'h17, 'h1C})) begin
				host.shift(1'b0, 2, 34'h3, so);
				chk("bypass", so[1:0], 2'b10);
			end
		end
		$display("test opcodes done");
		ir(`JID_OP_SAMPLE);
		host.shift(1'b0, 8, 34'h3C, so);
		chk("snapshot", so[7:0], 8'h96);
		@(posedge hclk);
		pins <= 8'hA5;
		ir(`JID_OP_EXTEST);
		host.shift(1'b0, 8, 34'h5A, so);
		chk("extest capture", so[7:0], 8'hA5);
		ahb(1'b0, `JID_OFS_STATUS, 32'h0);
		chk("extest pins", bscan_drive, 8'h5A);
		ir(`JID_OP_RESET);
		host.shift(1'b0, 1, 34'h1, so);
		ahb(1'b0, `JID_OFS_STATUS, 32'h0);
		chk("static reset", static_reset_out, 1'b1);
		ir(`JID_OP_WORD);
		chk("ir protected", so[4:0], 5'h11);
		host.shift(1'b0, 34, {1'b0, 32'h40, 1'b1}, so);
		ahb(1'b0, `JID_OFS_STATUS, 32'h0);
		chk("reset blocks", rv[8], 1'b0);
		ir(`JID_OP_RESET);
		host.shift(1'b0, 1, 34'h0, so);
		ahb(1'b1, `JID_OFS_CFG, 32'h5);
		chk("static release", static_reset_out, 1'b0);
		ir(`JID_OP_NEXUS);
		host.shift(1'b0, 8, {26'h0, 7'h2B, 1'b1}, so);
		ahb(1'b0, `JID_OFS_STATUS, 32'h0);
		chk("fuse blocks", rv[8], 1'b0);
		ahb(1'b1, `JID_OFS_CFG, 32'h1);
		ir(`JID_OP_BYPASS);
		chk("no protect feature", so[4:0], 5'h01);
		ahb(1'b1, `JID_OFS_CFG, 32'h5);
		ir(`JID_OP_ERASE);
		chk("ir fuse", so[4:0], 5'h11);
		ahb(1'b0, `JID_OFS_CFG, 32'h0);
		chk("erase", rv, 32'h4);
		chk("erase pulses", 34'(n_erase), 34'h2);
		$display("test security done");
		ir(`JID_OP_NEXUS);
		host.shift(1'b0, 8, {26'h0, 7'h2B, 1'b1}, so);
		ahb(1'b0, `JID_OFS_ADDR, 32'h0);
		chk("addr", rv[6:0], 7'h2B);
		ahb(1'b0, `JID_OFS_STATUS, 32'h0);
		chk("busy dir", rv[8:7], 2'b11);
		host.shift(1'b0, 34, 34'h0, so);
		chk("busy scan", so[0], 1'b1);
		ahb(1'b1, `JID_OFS_RDATA, 32'h3C5A_9600);
		ahb(1'b1, `JID_OFS_DONE, 32'h0);
		host.shift(1'b0, 34, 34'h0, so);
		chk("read scan", so, {32'h3C5A_9600, 2'b00});
		ir(`JID_OP_SIZED);
		host.shift(1'b0, 34, {1'b0, 32'h40, 1'b0}, so);
		host.shift(1'b0, 34, {32'hDEAD_BEEF, 2'b00}, so);
		ahb(1'b0, `JID_OFS_WDATA, 32'h0);
		chk("wdata", rv, 32'hDEAD_BEEF);
		ahb(1'b1, `JID_OFS_DONE, 32'h2);
		ahb(1'b0, `JID_OFS_STATUS, 32'h0);
		chk("error", rv[9:8], 2'b10);
		ir(`JID_OP_BLOCK);
		host.shift(1'b0, 34, {32'h1122_3344, 2'b00}, so);
		chk("block status", so[1:0], 2'b10);
		ahb(1'b0, `JID_OFS_ADDR, 32'h0);
		chk("block addr", rv, 32'h0000_0040 + `JID_ADDR_STEP);
		ahb(1'b0, `JID_OFS_WDATA, 32'h0);
		chk("block wdata", rv, 32'h1122_3344);
		ahb(1'b1, `JID_OFS_DONE, 32'h0);
		ir(`JID_OP_MEMSVC);
		host.shift(1'b0, 8, {26'h0, 7'h33, 1'b1}, so);
		ahb(1'b0, `JID_OFS_ADDR, 32'h0);
		chk("memsvc addr", rv, 32'h0000_0033);
		ahb(1'b0, `JID_OFS_STATUS, 32'h0);
		chk("memsvc busy", rv[8], 1'b1);
		ahb(1'b1, `JID_OFS_DONE, 32'h0);
		$display("test access done");
		ir(`JID_OP_SYNC);
		host.shift(1'b0, 16, 34'hFFFF, so);
		ahb(1'b0, `JID_OFS_STATUS, 32'h0);
		chk("sync busy", rv[8], 1'b1);
		ir(`JID_OP_CANCEL);
		ahb(1'b0, `JID_OFS_STATUS, 32'h0);
		chk("cancel", rv[9:8], 2'b10);
		ir(`JID_OP_HALT);
		host.home();
		ahb(1'b0, `JID_OFS_STATUS, 32'h0);
		chk("trst", {rv[12], rv[4:0]}, 6'h01);
		$display("test sync and cancel done");
		wrap_up();
	end
endmodule // tb_top
`default_nettype wire
